// ---- common/afs_pkg.sv ----
// Constants, types and register map of the antenna link frame sync config block.
// Assumes a 40 MHz core clock and a 32-bit APB register bus.
// Summary of operation
// [RULE1] After reset the interface is disabled and its memories sleep.
// [RULE2] Software wakes the memories first, then enables the module.
// [RULE3] Protocol mode, OBSAI or CPRI, is a software setting after reset.
// [RULE4] All links run the one protocol mode currently selected.
// [RULE5] RP1 mode source gives a 30.72 MHz frame clock and frame burst.
// [RULE6] Non-RP1 radio sync period lies between 1 ms and 10 ms.
// [RULE7] Non-RP1 PHY sync pulses at each UMTS frame boundary.
// [RULE8] Each line runs at half, quarter or eighth of PLL output.
// [RULE9] Each link pair has its own rate: half, quarter or eighth.
// [RULE10] PLL multiplier follows protocol and reference clock selection.
// [RULE11] Line rates: CPRI 4.9152/2.4576/1.2288, OBSAI 6.250/3.072/1.536 Gbps.
// [RULE12] RP1 timer syncs on frame burst and counts frame clock.
// [RULE13] Single-ended: radio timer on radio sync, PHY timer on PHY sync.
// [RULE14] Frame event output derived from frame clock and frame sync; single-ended mode counts core cycles, not frame clock.
// [RULE15] Frame event period and offset are programmable.
// [RULE16] Frame event output is not edge aligned to frame clock.
// [RULE17] Reference and frame sync clocks come from one common source.
// [RULE18] Unused lanes are disabled by register and stay inactive.
// [RULE19] Whole peripheral stays disabled by register when unneeded.
// [RULE20] Disabled or asleep: links idle, inputs and sync ignored.
`default_nettype none
package afs_pkg;
   localparam int unsigned ADDR_W   = 8;
   localparam int unsigned N_LINK   = 6;
   localparam int unsigned N_PAIR   = 3;
   // Register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_LANE     = 8'h04;
   localparam logic [7:0] OFS_RATE     = 8'h08;
   localparam logic [7:0] OFS_PLL      = 8'h0c;
   localparam logic [7:0] OFS_EVT_PER  = 8'h10;
   localparam logic [7:0] OFS_EVT_OFS  = 8'h14;
   localparam logic [7:0] OFS_STATUS   = 8'h18;
   localparam logic [7:0] OFS_SYNC_CNT = 8'h1c;
   localparam logic [7:0] OFS_RATE01   = 8'h20;
   localparam logic [7:0] OFS_RATE2    = 8'h24;
   // CTRL, LANE and STATUS fields
   localparam int unsigned CTRL_MEM_WAKE = 0;
   localparam int unsigned CTRL_MOD_EN   = 1;
   localparam int unsigned CTRL_CPRI     = 2;
   localparam int unsigned CTRL_SYNC_SE  = 3;
   localparam int unsigned LANE_RX_POS   = 8;
   localparam int unsigned STAT_RAD_ERR  = 2;
   // Reset values
   localparam logic [15:0] EVT_PER_RST  = 16'hffff;
   localparam logic [15:0] EVT_OFS_RST  = 16'h0000;
   localparam logic [1:0]  REFSEL_RST   = 2'h0;
   // Radio sync period window and core clock
   localparam int unsigned CLK_MHZ      = 40;
   localparam int unsigned RADIO_MIN_US = 1000;
   localparam int unsigned RADIO_MAX_US = 10000;
   localparam int unsigned RAD_CNT_W    = 19;

   typedef enum logic [1:0] {
      RATE_HALF    = 2'b00,
      RATE_QUARTER = 2'b01,
      RATE_EIGHTH  = 2'b10
   } afs_rate_t;

   typedef enum logic [1:0] {
      ST_OFF    = 2'b00,
      ST_MEM_ON = 2'b01,
      ST_ACTIVE = 2'b10
   } afs_state_t;

   typedef struct packed {
      logic                  proto_cpri;
      logic [N_LINK-1:0]     tx_en;
      logic [N_LINK-1:0]     rx_en;
      afs_rate_t [N_PAIR-1:0] rate;
      logic [4:0]            pll_mult;
   } afs_link_cfg_t;

   // Multiplier by protocol and reference clock: 122.88, 153.60, 307.20 MHz
   function automatic logic [4:0] afs_pll_mult(input logic cpri, input logic [1:0] refsel);
      logic [4:0] m;
      m = 5'h00;
      unique case (refsel)
         2'h0:    m = cpri ? 5'h14 : 5'h19;
         2'h1:    m = cpri ? 5'h10 : 5'h14;
         default: m = cpri ? 5'h08 : 5'h0a;
      endcase
      return m;
   endfunction

   // Line rate in units of 100 kbit/s
   function automatic logic [15:0] afs_line_rate(input logic cpri, input afs_rate_t r);
      logic [15:0] v;
      v = 16'h0000;
      unique case (r)
         RATE_HALF:    v = cpri ? 16'hc000 : 16'hf424;
         RATE_QUARTER: v = cpri ? 16'h6000 : 16'h7800;
         default:      v = cpri ? 16'h3000 : 16'h3c00;
      endcase
      return v;
   endfunction
endpackage
`default_nettype wire

// ---- dv/afs_sync_src.sv ----
// Frame sync source model: frame clock, burst, radio and phy sync pins.
// Assumes it runs off the core clock, so all pins change after its edge.
`timescale 1ns/100ps
`default_nettype none
module afs_sync_src (
   // Clock
   input  wire logic clock_i,
   // Pins
   output var logic  frame_clk_o,
   output var logic  burst_o,
   output var logic  radio_o,
   output var logic  phy_o
);
   initial begin
      frame_clk_o = 1'b0;
      burst_o = 1'b0;
      radio_o = 1'b0;
      phy_o = 1'b0;
   end
   // Scaled down rate, same source as core clock
   always @(posedge clock_i) begin
      frame_clk_o <= ~frame_clk_o;
   end
   task automatic strobe(input int which);
      @(posedge clock_i);
      burst_o <= (which == 0);
      radio_o <= (which == 1);
      phy_o <= (which > 1);
      repeat (2) @(posedge clock_i);
      {burst_o, radio_o, phy_o} <= 3'h0;
      @(posedge clock_i);
   endtask
endmodule
`default_nettype wire

// ---- dv/afs_top_assertions.sv ----
// Checker for afs_top: power order, lane gating, sync routing, locks.
// Assumes it is bound to afs_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module afs_top_assertions (
   // Clock and reset
   input wire logic                   clock_i,
   input wire logic                   rst_b_i,
   // Pins
   input wire logic                   diff_frame_burst_in_i,
   input wire logic                   radio_sync_in_i,
   input wire logic                   phy_frame_sync_in_i,
   // Outputs
   input wire logic                   ext_frame_event_out_o,
   input wire logic                   rp1_timer_sync_o,
   input wire logic                   radio_timer_sync_o,
   input wire logic                   phy_timer_sync_o,
   input wire logic                   mem_sleep_o,
   input wire logic                   module_active_o,
   input wire afs_pkg::afs_link_cfg_t link_cfg_o
);
   import afs_pkg::*;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   // Pipeline depth kept loose by one cycle
   sequence s_pin_rose(x);
      ($past(x, 2) && !$past(x, 3)) || ($past(x, 3) && !$past(x, 4));
   endsequence
   sequence s_was_active;
      module_active_o || $past(module_active_o) || $past(module_active_o, 2);
   endsequence
   property p_sleep;
      mem_sleep_o |-> !module_active_o;
   endproperty
   a_sleep: assert property (p_sleep) else $error("active while asleep");
   property p_order;
      $rose(module_active_o) |-> !$past(mem_sleep_o);
   endproperty
   a_order: assert property (p_order) else $error("active straight from off");
   property p_lanes;
      !$past(module_active_o) |-> link_cfg_o.tx_en == '0 && link_cfg_o.rx_en == '0;
   endproperty
   a_lanes: assert property (p_lanes) else $error("lanes on while inactive");
   property p_gate;
      (rp1_timer_sync_o || radio_timer_sync_o || phy_timer_sync_o) |->
         (s_was_active or $past(module_active_o, 3));
   endproperty
   a_gate: assert property (p_gate) else $error("sync pulse while inactive");
   property p_rp1;
      rp1_timer_sync_o |-> s_pin_rose(diff_frame_burst_in_i);
   endproperty
   a_rp1: assert property (p_rp1) else $error("rp1 sync without burst");
   property p_radio;
      radio_timer_sync_o |-> s_pin_rose(radio_sync_in_i);
   endproperty
   a_radio: assert property (p_radio) else $error("radio sync without pin");
   property p_phy;
      phy_timer_sync_o |-> s_pin_rose(phy_frame_sync_in_i);
   endproperty
   a_phy: assert property (p_phy) else $error("phy sync without pin");
   property p_evt;
      ext_frame_event_out_o |-> s_was_active;
   endproperty
   a_evt: assert property (p_evt) else $error("frame event while inactive");
   // Settings freeze once active has settled
   property p_lock;
      module_active_o [*3] |-> $stable(link_cfg_o.proto_cpri) && $stable(link_cfg_o.rate);
   endproperty
   a_lock: assert property (p_lock) else $error("mode or rate moved while active");
endmodule
`default_nettype wire

// ---- dv/tb_afs_top.sv ----
// Testbench for afs_top: registers, power order, rates, sync and events.
// Assumes afs_sync_src drives the sync pins and the checker is bound.
`timescale 1ns/100ps
`default_nettype none
module tb_afs_top;
   import afs_pkg::*;
   logic              clock_i, rst_b_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
   logic [ADDR_W-1:0] paddr_i;
   logic [31:0]       pwdata_i, prdata_o, q;
   logic              diff_frame_clock_in_i, diff_frame_burst_in_i, radio_sync_in_i;
   logic              phy_frame_sync_in_i, ext_frame_event_out_o, rp1_timer_sync_o;
   logic              radio_timer_sync_o, phy_timer_sync_o, mem_sleep_o, module_active_o, e;
   afs_link_cfg_t     link_cfg_o;
   int                mismatches, checked, cycles, evt_n, p, r;
   int                mp[2][3] = '{'{25, 20, 10}, '{20, 16, 8}};
   int                rt[2][3] = '{'{62500, 30720, 15360}, '{49152, 24576, 12288}};
   afs_top #(.RADIO_MIN_CYC(20), .RADIO_MAX_CYC(200)) u_afs_top (.*);
   afs_sync_src u_afs_sync_src (.clock_i, .frame_clk_o(diff_frame_clock_in_i),
      .burst_o(diff_frame_burst_in_i), .radio_o(radio_sync_in_i), .phy_o(phy_frame_sync_in_i));
   always #12.5 clock_i = ~clock_i;
   task automatic give_verdict;
      if (mismatches == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (ext_frame_event_out_o === 1'b1) evt_n <= evt_n + 1;
      if (cycles == 3000) begin
         mismatches++;
         give_verdict();
      end
   end
   task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
      checked++;
      if (g !== x) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", n, x, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      do @(posedge clock_i); while (pready_o !== 1'b1);
      q = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0000_0000);
      chk($sformatf("reg_%h", a), x, q);
   endtask
   task automatic st(input int n);
      repeat (n) @(posedge clock_i);
      @(negedge clock_i);
   endtask
   // Any 64-cycle window holds a whole number of event periods
   task automatic evt_chk(input int x);
      int n0;
      n0 = evt_n;
      st(64);
      chk("events", x, evt_n - n0);
   endtask
   initial begin
      {clock_i, rst_b_i, psel_i, penable_i, pwrite_i} = 5'h00;
      paddr_i = 8'h00;
      pwdata_i = 32'h0000_0000;
      {mismatches, checked, cycles, evt_n} = '0;
      repeat (5) @(posedge clock_i);
      rst_b_i <= 1'b1;
      st(0);
      chk("mem_sleep", 1, mem_sleep_o);
      chk("active", 0, module_active_o);
      rd(OFS_CTRL, 32'h0000_0000);
      rd(OFS_EVT_PER, {16'h0000, EVT_PER_RST});
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk("slverr", 1, e);
      chk("unmapped", 0, q);
      for (p = 0; p < 2; p++) begin
         wr(OFS_CTRL, p << CTRL_CPRI);
         for (r = 0; r < 3; r++) begin
            wr(OFS_PLL, r);
            wr(OFS_RATE, r | ((r + 1) % 3) << 2 | ((r + 2) % 3) << 4);
            rd(OFS_PLL, mp[p][r] << 8 | r);
            rd(OFS_RATE01, rt[p][r] | rt[p][(r + 1) % 3] << 16);
            rd(OFS_RATE2, rt[p][(r + 2) % 3]);
         end
      end
      wr(OFS_RATE, 32'h0000_003f);
      wr(OFS_PLL, 32'h0000_0003);
      rd(OFS_PLL, 32'h0000_0802);
      chk("pll_mult", 5'h08, link_cfg_o.pll_mult);
      chk("rates", 6'h12, link_cfg_o.rate);
      wr(OFS_LANE, 32'h0000_0305);
      wr(OFS_CTRL, 32'h0000_0005);
      st(1);
      rd(OFS_STATUS, 32'h0000_0001);
      wr(OFS_CTRL, 32'h0000_0007);
      st(1);
      rd(OFS_STATUS, 32'h0000_0002);
      st(1);
      chk("tx_en", 6'h05, link_cfg_o.tx_en);
      chk("rx_en", 6'h03, link_cfg_o.rx_en);
      chk("proto", 1, link_cfg_o.proto_cpri);
      wr(OFS_CTRL, 32'h0000_0003);
      wr(OFS_RATE, 32'h0000_0000);
      rd(OFS_CTRL, 32'h0000_0007);
      rd(OFS_RATE, 32'h0000_0012);
      wr(OFS_EVT_PER, 32'h0000_0003);
      wr(OFS_EVT_OFS, 32'h0000_0001);
      u_afs_sync_src.strobe(0);
      st(2);
      evt_chk(8);
      rd(OFS_SYNC_CNT, 32'h0000_0001);
      wr(OFS_CTRL, 32'h0000_0005);
      st(2);
      chk("tx_off", 0, link_cfg_o.tx_en);
      u_afs_sync_src.strobe(1);
      wr(OFS_CTRL, 32'h0000_000f);
      st(2);
      evt_chk(16);
      u_afs_sync_src.strobe(1);
      u_afs_sync_src.strobe(1);
      u_afs_sync_src.strobe(2);
      st(3);
      rd(OFS_STATUS, 32'h0000_0006);
      wr(OFS_STATUS, 32'h0000_0004);
      rd(OFS_STATUS, 32'h0000_0002);
      st(50);
      u_afs_sync_src.strobe(1);
      st(3);
      rd(OFS_STATUS, 32'h0000_0002);
      rd(OFS_SYNC_CNT, 32'h0001_0301);
      wr(OFS_CTRL, 32'h0000_0000);
      st(2);
      chk("asleep", 1, mem_sleep_o);
      give_verdict();
   end
endmodule
bind afs_top afs_top_assertions u_afs_top_assertions (.*);
`default_nettype wire

// ---- rtl/afs_frame_timer.sv ----
// Frame timer: counts ticks, restarts on frame sync, pulses at a set offset.
// Assumes tick and sync are one-cycle pulses on clock_i.
`timescale 1ns/100ps
`default_nettype none
module afs_frame_timer (
   // Clock and reset
   input  wire logic        clock_i,
   input  wire logic        rst_b_i,
   // Control
   input  wire logic        en_i,
   input  wire logic        tick_i,
   input  wire logic        sync_i,
   input  wire logic [15:0] period_i,
   input  wire logic [15:0] offset_i,
   // Event
   output logic             event_o
);
   logic [15:0] cnt_ff;
   logic        event_ff;

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_ff <= 16'h0000;
      end else if (!en_i || sync_i) begin
         cnt_ff <= 16'h0000;
      end else if (tick_i) begin
         cnt_ff <= (cnt_ff == period_i) ? 16'h0000 : 16'(cnt_ff + 16'h0001); // [RULE15]
      end
   end

   // Registered on core clock, so not aligned to the frame clock edges
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         event_ff <= 1'b0;
      end else begin
         event_ff <= en_i && tick_i && !sync_i && (cnt_ff == offset_i); // [RULE14] [RULE16]
      end
   end

   assign event_o = event_ff;
endmodule
`default_nettype wire

// ---- rtl/afs_sync_edge.sv ----
// Rising-edge pulse detector for a group of synchronous frame sync inputs.
// Assumes the inputs are already synchronous to clock_i.
`timescale 1ns/100ps
`default_nettype none
module afs_sync_edge #(
   parameter int unsigned WIDTH = 4
) (
   // Clock and reset
   input  wire logic             clock_i,
   input  wire logic             rst_b_i,
   // Control and pins
   input  wire logic             en_i,
   input  wire logic [WIDTH-1:0] level_i,
   // Pulses
   output logic [WIDTH-1:0]      rise_o
);
   logic [WIDTH-1:0] prev_ff;
   logic [WIDTH-1:0] rise_ff;

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prev_ff <= '0;
      end else begin
         prev_ff <= level_i;
      end
   end

   // Gated so a disabled block sees no sync events
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rise_ff <= '0;
      end else begin
         rise_ff <= en_i ? (level_i & ~prev_ff) : '0; // [RULE20]
      end
   end

   assign rise_o = rise_ff;
endmodule
`default_nettype wire

// ---- rtl/afs_top.sv ----
// Antenna link frame sync config block: APB registers, power state,
// per-pair rate and PLL setup, sync timer routing and frame event output.
// Assumes frame sync pins are synchronous to clock_i and APB is in this domain.
`timescale 1ns/100ps
`default_nettype none
module afs_top #(
   parameter int unsigned RADIO_MIN_CYC = afs_pkg::RADIO_MIN_US * afs_pkg::CLK_MHZ,
   parameter int unsigned RADIO_MAX_CYC = afs_pkg::RADIO_MAX_US * afs_pkg::CLK_MHZ
) (
   // Clock and reset
   input  wire logic                        clock_i,
   input  wire logic                        rst_b_i,
   // APB slave
   input  wire logic                        psel_i,
   input  wire logic                        penable_i,
   input  wire logic                        pwrite_i,
   input  wire logic [afs_pkg::ADDR_W-1:0]  paddr_i,
   input  wire logic [31:0]                 pwdata_i,
   output logic [31:0]                      prdata_o,
   output logic                             pready_o,
   output logic                             pslverr_o,
   // Frame sync pins
   input  wire logic                        diff_frame_clock_in_i,
   input  wire logic                        diff_frame_burst_in_i,
   input  wire logic                        radio_sync_in_i,
   input  wire logic                        phy_frame_sync_in_i,
   // Frame event and timer syncs
   output logic                             ext_frame_event_out_o,
   output logic                             rp1_timer_sync_o,
   output logic                             radio_timer_sync_o,
   output logic                             phy_timer_sync_o,
   // Link control
   output logic                             mem_sleep_o,
   output logic                             module_active_o,
   output afs_pkg::afs_link_cfg_t           link_cfg_o
);
   import afs_pkg::*;

   afs_state_t          state_ff;
   afs_state_t          nxt_state;
   logic                mem_wake_ff;
   logic                mod_en_ff;
   logic                cpri_ff;
   logic                sync_se_ff;
   logic [N_LINK-1:0]   tx_en_ff;
   logic [N_LINK-1:0]   rx_en_ff;
   afs_rate_t [N_PAIR-1:0] rate_ff;
   logic [1:0]          refsel_ff;
   logic [15:0]         evt_per_ff;
   logic [15:0]         evt_ofs_ff;
   logic                rad_err_ff;
   logic                rad_seen_ff;
   logic [RAD_CNT_W-1:0] rad_cnt_ff;
   logic [7:0]          rp1_frm_ff;
   logic [7:0]          rad_frm_ff;
   logic [7:0]          phy_frm_ff;
   logic [31:0]         prdata_ff;
   afs_link_cfg_t       link_cfg_ff;
   logic                rp1_sync_ff;
   logic                rad_sync_ff;
   logic                phy_sync_ff;

   logic                active;
   logic                wr_en;
   logic                rd_setup;
   logic                addr_hit;
   logic [31:0]         nxt_prdata;
   logic [3:0]          edges;
   logic                frm_tick;
   logic                frm_sync;
   logic                rad_bad;

   assign active   = (state_ff == ST_ACTIVE);
   assign wr_en    = psel_i && penable_i && pwrite_i && addr_hit;
   assign rd_setup = psel_i && !penable_i;

   // Address decode
   always_comb begin
      unique case (paddr_i)
         OFS_CTRL, OFS_LANE, OFS_RATE, OFS_PLL, OFS_EVT_PER, OFS_EVT_OFS,
         OFS_STATUS, OFS_SYNC_CNT, OFS_RATE01, OFS_RATE2: addr_hit = 1'b1;
         default:                                          addr_hit = 1'b0;
      endcase
   end

   // Zero wait states; unmapped offsets answer with an error
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && !addr_hit;

   // Power state: module only becomes active after the memories are awake
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_OFF: begin
            if (mem_wake_ff) nxt_state = ST_MEM_ON;
         end
         ST_MEM_ON: begin
            if (!mem_wake_ff) nxt_state = ST_OFF;
            else if (mod_en_ff) nxt_state = ST_ACTIVE; // [RULE2]
         end
         ST_ACTIVE: begin
            if (!mem_wake_ff) nxt_state = ST_OFF;
            else if (!mod_en_ff) nxt_state = ST_MEM_ON; // [RULE19]
         end
         default: nxt_state = ST_OFF;
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_ff <= ST_OFF; // [RULE1]
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Control register; reset leaves module off and memories asleep
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         mem_wake_ff <= 1'b0; // [RULE1]
         mod_en_ff   <= 1'b0;
         cpri_ff     <= 1'b0;
         sync_se_ff  <= 1'b0;
      end else if (wr_en && paddr_i == OFS_CTRL) begin
         mem_wake_ff <= pwdata_i[CTRL_MEM_WAKE];
         mod_en_ff   <= pwdata_i[CTRL_MOD_EN];
         // Mode frozen while running so every link shares one protocol
         if (!active) begin
            cpri_ff    <= pwdata_i[CTRL_CPRI];    // [RULE3] [RULE4]
            sync_se_ff <= pwdata_i[CTRL_SYNC_SE];
         end
      end
   end

   // Lane enables
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         tx_en_ff <= '0;
         rx_en_ff <= '0;
      end else if (wr_en && paddr_i == OFS_LANE) begin
         tx_en_ff <= pwdata_i[N_LINK-1:0];                         // [RULE18]
         rx_en_ff <= pwdata_i[LANE_RX_POS +: N_LINK];
      end
   end

   // Per-pair rate; the reserved code leaves that pair unchanged
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rate_ff <= {N_PAIR{RATE_HALF}};
      end else if (wr_en && paddr_i == OFS_RATE && !active) begin
         for (int p = 0; p < N_PAIR; p++) begin
            if (pwdata_i[2*p +: 2] != 2'b11) begin
               rate_ff[p] <= afs_rate_t'(pwdata_i[2*p +: 2]); // [RULE8] [RULE9]
            end
         end
      end
   end

   // Reference clock selection; the reserved code is ignored
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         refsel_ff <= REFSEL_RST;
      end else if (wr_en && paddr_i == OFS_PLL && !active && pwdata_i[1:0] != 2'b11) begin
         refsel_ff <= pwdata_i[1:0]; // [RULE10]
      end
   end

   // Frame event period and offset
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         evt_per_ff <= EVT_PER_RST;
         evt_ofs_ff <= EVT_OFS_RST;
      end else if (wr_en) begin
         if (paddr_i == OFS_EVT_PER) evt_per_ff <= pwdata_i[15:0]; // [RULE15]
         if (paddr_i == OFS_EVT_OFS) evt_ofs_ff <= pwdata_i[15:0];
      end
   end

   // Sync pin edges, ignored unless active
   afs_sync_edge #(
      .WIDTH (4)
   ) u_edge (
      .clock_i (clock_i),
      .rst_b_i (rst_b_i),
      .en_i    (active), // [RULE20]
      .level_i ({phy_frame_sync_in_i, radio_sync_in_i,
                 diff_frame_burst_in_i, diff_frame_clock_in_i}),
      .rise_o  (edges)
   );

   // RP1 mode counts frame clock edges and syncs on the burst;
   // single-ended mode counts core cycles and syncs on the PHY sync.
   assign frm_tick = sync_se_ff ? 1'b1 : edges[0];       // [RULE12]
   assign frm_sync = sync_se_ff ? edges[3] : edges[1];   // [RULE12] [RULE13]

   afs_frame_timer u_evt (
      .clock_i  (clock_i),
      .rst_b_i  (rst_b_i),
      .en_i     (active),
      .tick_i   (frm_tick),
      .sync_i   (frm_sync),
      .period_i (evt_per_ff),
      .offset_i (evt_ofs_ff),
      .event_o  (ext_frame_event_out_o) // [RULE14]
   );

   // Timer sync pulses routed by sync source
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rp1_sync_ff <= 1'b0;
         rad_sync_ff <= 1'b0;
         phy_sync_ff <= 1'b0;
      end else begin
         rp1_sync_ff <= !sync_se_ff && edges[1]; // [RULE12]
         rad_sync_ff <= sync_se_ff && edges[2];  // [RULE13]
         phy_sync_ff <= sync_se_ff && edges[3];  // [RULE13]
      end
   end

   assign rp1_timer_sync_o   = rp1_sync_ff;
   assign radio_timer_sync_o = rad_sync_ff;
   assign phy_timer_sync_o   = phy_sync_ff;

   // Frame boundary counters for software
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rp1_frm_ff <= 8'h00;
         rad_frm_ff <= 8'h00;
         phy_frm_ff <= 8'h00;
      end else begin
         if (rp1_sync_ff) rp1_frm_ff <= 8'(rp1_frm_ff + 8'h01);
         if (rad_sync_ff) rad_frm_ff <= 8'(rad_frm_ff + 8'h01);
         if (phy_sync_ff) phy_frm_ff <= 8'(phy_frm_ff + 8'h01);
      end
   end

   // Radio sync period monitor; the first edge only starts the count
   assign rad_bad = rad_seen_ff &&
                    ((rad_cnt_ff < RAD_CNT_W'(RADIO_MIN_CYC)) ||
                     (rad_cnt_ff > RAD_CNT_W'(RADIO_MAX_CYC)));

   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rad_cnt_ff  <= '0;
         rad_seen_ff <= 1'b0;
      end else if (!active || !sync_se_ff) begin
         rad_cnt_ff  <= '0;
         rad_seen_ff <= 1'b0;
      end else if (rad_sync_ff) begin
         rad_cnt_ff  <= RAD_CNT_W'(1);
         rad_seen_ff <= 1'b1;
      end else if (rad_cnt_ff != '1) begin
         rad_cnt_ff  <= RAD_CNT_W'(rad_cnt_ff + RAD_CNT_W'(1));
      end
   end

   // Sticky error, write one to clear; a new error wins over the clear
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rad_err_ff <= 1'b0;
      end else if (rad_sync_ff && rad_bad) begin
         rad_err_ff <= 1'b1; // [RULE6]
      end else if (wr_en && paddr_i == OFS_STATUS && pwdata_i[STAT_RAD_ERR]) begin
         rad_err_ff <= 1'b0;
      end
   end

   // Link configuration, lanes forced idle unless active
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         link_cfg_ff <= '0;
      end else begin
         link_cfg_ff.proto_cpri <= cpri_ff;                              // [RULE4]
         link_cfg_ff.tx_en      <= active ? tx_en_ff : '0;               // [RULE18] [RULE20]
         link_cfg_ff.rx_en      <= active ? rx_en_ff : '0;               // [RULE18] [RULE20]
         link_cfg_ff.rate       <= rate_ff;                              // [RULE9]
         link_cfg_ff.pll_mult   <= afs_pll_mult(cpri_ff, refsel_ff);     // [RULE10]
      end
   end

   assign link_cfg_o      = link_cfg_ff;
   assign mem_sleep_o     = (state_ff == ST_OFF); // [RULE1]
   assign module_active_o = active;

   // Read mux
   always_comb begin
      nxt_prdata = 32'h0000_0000;
      unique case (paddr_i)
         OFS_CTRL: begin
            nxt_prdata[CTRL_MEM_WAKE] = mem_wake_ff;
            nxt_prdata[CTRL_MOD_EN]   = mod_en_ff;
            nxt_prdata[CTRL_CPRI]     = cpri_ff;
            nxt_prdata[CTRL_SYNC_SE]  = sync_se_ff;
         end
         OFS_LANE: begin
            nxt_prdata[N_LINK-1:0]             = tx_en_ff;
            nxt_prdata[LANE_RX_POS +: N_LINK]  = rx_en_ff;
         end
         OFS_RATE:     nxt_prdata[2*N_PAIR-1:0] = rate_ff;
         OFS_PLL: begin
            nxt_prdata[1:0]  = refsel_ff;
            nxt_prdata[12:8] = afs_pll_mult(cpri_ff, refsel_ff);
         end
         OFS_EVT_PER:  nxt_prdata[15:0] = evt_per_ff;
         OFS_EVT_OFS:  nxt_prdata[15:0] = evt_ofs_ff;
         OFS_STATUS: begin
            nxt_prdata[1:0]          = state_ff;
            nxt_prdata[STAT_RAD_ERR] = rad_err_ff;
         end
         OFS_SYNC_CNT: nxt_prdata[23:0] = {phy_frm_ff, rad_frm_ff, rp1_frm_ff};
         OFS_RATE01:   nxt_prdata = {afs_line_rate(cpri_ff, rate_ff[1]),
                                     afs_line_rate(cpri_ff, rate_ff[0])}; // [RULE11]
         OFS_RATE2:    nxt_prdata[15:0] = afs_line_rate(cpri_ff, rate_ff[2]); // [RULE11]
         default:      nxt_prdata = 32'h0000_0000;
      endcase
   end

   // Read data captured in the setup phase, stable through the access phase
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prdata_ff <= 32'h0000_0000;
      end else if (rd_setup && !pwrite_i) begin
         prdata_ff <= nxt_prdata;
      end
   end

   assign prdata_o = prdata_ff;
endmodule
`default_nettype wire
